// [tb/host_link_model.sv]
// serial front end seen from the host: no-op and bad frames, readback capture
// assumes the bench calls its tasks from one process only
`timescale 1ns/1ps
module host_link_model (
   input wire logic clock,
   input wire logic [15:0] fault_word,
   input wire logic fault_word_valid,
   output logic nop_cmd,
   output logic frame_check_error
);
   int words = 0;
   logic [15:0] last_word = 16'h0;

   initial begin
      nop_cmd = 1'b0;
      frame_check_error = 1'b0;
   end

   // keep-alive command; the host must send it inside the timeout
   task automatic nop();
      @(posedge clock);
      nop_cmd <= 1'b1;
      @(posedge clock);
      nop_cmd <= 1'b0;
   endtask

   // a frame whose check fails
   task automatic bad_frame();
      @(posedge clock);
      frame_check_error <= 1'b1;
      @(posedge clock);
      frame_check_error <= 1'b0;
   endtask

   // catch each fault word shifted out by readback
   always @(posedge clock) begin
      if (fault_word_valid === 1'b1) begin
         words <= words + 1;
         last_word <= fault_word;
      end
   end
endmodule

// [tb/tb_loop_dac_control.sv]
// self-checking bench for the loop converter control block
// assumes CYCLES_MS of 10, so the 50 ms timeout is 500 cycles
`timescale 1ns/1ps
module tb_loop_dac_control;
   import loop_dac_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h0;
   logic [15:0] wdata = 16'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic loop_supply_low = 1'b0;
   logic alarm_dir_pin = 1'b0;
   logic nop_cmd, frame_check_error, fault_word_valid, fault_alert_pin, force_alarm;
   logic alarm_upscale, min_current, monitor_sel_temp, monitor_enable, ref_power_down, irq;
   logic [15:0] rdata, fault_word, d;
   logic [31:0] seed = 32'h2de1;
   int failures = 0;
   int n_checks = 0;
   int cnt;

   always #2.5 clock = ~clock;

   loop_dac_control #(.CYCLES_MS(10)) uut (.clock(clock), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .nop_cmd(nop_cmd),
      .frame_check_error(frame_check_error), .loop_supply_low(loop_supply_low),
      .alarm_dir_pin(alarm_dir_pin), .fault_word(fault_word),
      .fault_word_valid(fault_word_valid), .fault_alert_pin(fault_alert_pin),
      .force_alarm(force_alarm), .alarm_upscale(alarm_upscale), .min_current(min_current),
      .monitor_sel_temp(monitor_sel_temp), .monitor_enable(monitor_enable),
      .ref_power_down(ref_power_down), .irq(irq));

   host_link_model host (.clock(clock), .fault_word(fault_word),
      .fault_word_valid(fault_word_valid), .nop_cmd(nop_cmd),
      .frame_check_error(frame_check_error));

   // galois-free shift register, fixed seed keeps runs repeatable
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
         failures++;
      end
   endtask

   task automatic end_sim();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   // bounded wait for the alert pin; running out ends the run
   task automatic wait_alert(input int n);
      int i;
      for (i = 0; i < n && fault_alert_pin !== 1'b1; i++) @(posedge clock);
      if (i == n) begin
         $display("CHECK FAILED %0t alert never came", $time);
         failures++;
         end_sim();
      end
      #1;
   endtask

   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      // reset values of the options
      rd_reg(CTRL_OFS, d);
      chk(d, 16'h7000, "ctrl reset");
      chk({12'h0, min_current, monitor_sel_temp, monitor_enable, ref_power_down}, 16'h0,
         "option outputs reset");
      $display("test defaults done");
      // random option bits, watchdog off
      for (int k = 0; k < 6; k++) begin
         seed = lfsr(seed);
         wr_reg(CTRL_OFS, seed[15:0] & 16'h0fdf);
         repeat (2) @(posedge clock);
         #1 chk({12'h0, min_current, monitor_sel_temp, monitor_enable, ref_power_down},
            {12'h0, seed[9:6]}, "option copies");
         rd_reg(CTRL_OFS, d);
         chk(d, seed[15:0] & 16'h0fc0, "ctrl readback");
      end
      $display("test options done");
      // read-only fault word and unmapped place
      wr_reg(FAULT_OFS, 16'hffff);
      rd_reg(FAULT_OFS, d);
      chk(d, 16'h0, "fault write ignored");
      rd_reg(8'h40, d);
      chk(d, 16'h0, "unmapped read");
      // readback on and off
      wr_reg(CTRL_OFS, 16'h0);
      repeat (2) @(posedge clock);
      cnt = host.words;
      host.nop();
      repeat (2) @(posedge clock);
      chk(host.words[15:0], cnt[15:0] + 16'h1, "readback word sent");
      wr_reg(CTRL_OFS, 16'h0800);
      repeat (2) @(posedge clock);
      cnt = host.words;
      host.nop();
      wr_reg(STATUS_OFS, 16'h0);
      repeat (2) @(posedge clock);
      chk(host.words[15:0], cnt[15:0], "readback suppressed");
      $display("test readback done");
      // low loop voltage, alert gated by its option
      wr_reg(CTRL_OFS, 16'h0);
      loop_supply_low <= 1'b1;
      repeat (3) @(posedge clock);
      rd_reg(FAULT_OFS, d);
      chk({15'h0, d[FLT_LOOP_LOW]}, 16'h1, "loop fault bit");
      chk({15'h0, fault_alert_pin}, 16'h0, "alert gated off");
      wr_reg(CTRL_OFS, 16'h0020);
      wait_alert(4);
      @(posedge clock);
      loop_supply_low <= 1'b0;
      wr_reg(STATUS_OFS, 16'h0007);
      $display("test loop voltage done");
      // frame error interrupt, masked and unmasked
      wr_reg(MASK_OFS, 16'h0002);
      host.bad_frame();
      repeat (2) @(posedge clock);
      #1 chk({15'h0, irq}, 16'h1, "irq raised");
      wr_reg(STATUS_OFS, 16'h0002);
      #1 chk({15'h0, irq}, 16'h0, "irq cleared");
      wr_reg(MASK_OFS, 16'h0);
      host.bad_frame();
      repeat (2) @(posedge clock);
      rd_reg(STATUS_OFS, d);
      chk(d, 16'h0002, "status sticky while masked");
      chk({15'h0, irq}, 16'h0, "irq masked");
      wr_reg(STATUS_OFS, 16'h0007);
      wr_reg(MASK_OFS, 16'h0001);
      $display("test interrupts done");
      // watchdog with alarm forcing, restarted once by a no-op
      seed = lfsr(seed);
      alarm_dir_pin <= seed[0];
      wr_reg(CTRL_OFS, 16'h1000);
      repeat (400) @(posedge clock);
      host.nop();
      repeat (400) @(posedge clock);
      #1 chk({15'h0, fault_alert_pin}, 16'h0, "restart held off timeout");
      wait_alert(300);
      chk({15'h0, force_alarm}, 16'h1, "alarm forced");
      chk({15'h0, alarm_upscale}, {15'h0, seed[0]}, "alarm direction");
      chk({15'h0, irq}, 16'h1, "link irq");
      rd_reg(FAULT_OFS, d);
      chk({15'h0, d[FLT_LINK]}, 16'h1, "link fault bit");
      // alarm option at bit 10 set: fault still flagged, current left alone
      wr_reg(STATUS_OFS, 16'h0001);
      repeat (2) @(posedge clock);
      chk(host.last_word, 16'h8000, "readback carries link fault");
      wr_reg(CTRL_OFS, 16'h1400);
      repeat (3) @(posedge clock);
      #1 chk({15'h0, fault_alert_pin}, 16'h0, "write restarts watchdog");
      wait_alert(700);
      repeat (2) @(posedge clock);
      #1 chk({15'h0, force_alarm}, 16'h0, "alarm not forced");
      $display("test watchdog done");
      end_sim();
   end
endmodule

// [verilog/event_flags.sv]
// sticky event flags with write-one-to-clear, mask and level interrupt
// assumes set pulses and write strobes share the clock
`timescale 1ns/1ps
module event_flags
   import loop_dac_pkg::*;
#(
   parameter int W = EV_W
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [W-1:0] set,
   input wire logic clear_wr,
   input wire logic mask_wr,
   input wire logic [W-1:0] wdata,
   output logic [W-1:0] status,
   output logic [W-1:0] mask,
   output logic irq
);
   // set beats clear so an event in the clear cycle survives
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         status <= '0;
      end else begin
         status <= (status & ~(clear_wr ? wdata : '0)) | set;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mask <= '0;
      end else if (mask_wr) begin
         mask <= wdata;
      end
   end

   assign irq = |(status & mask);
endmodule

// [verilog/link_watchdog.sv]
// link watchdog: ms prescaler plus ms counter, one timeout pulse per expiry
// assumes restart is a one-cycle pulse in the clock domain
`timescale 1ns/1ps
module link_watchdog
   import loop_dac_pkg::*;
#(
   parameter int CYCLES_MS = CYCLES_PER_MS
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic enable,
   input wire logic restart,
   input wire logic [2:0] period_sel,
   output logic timeout
);
   logic [31:0] pre_reg;
   logic [MS_W-1:0] ms_reg;
   logic expired_reg;
   logic tick;
   logic [MS_W-1:0] limit;

   assign tick = (pre_reg == 32'(CYCLES_MS - 1));
   assign limit = timeout_ms(period_sel);

   // counting stops after expiry so the fault is reported once
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pre_reg <= 32'h0;
         ms_reg <= '0;
         expired_reg <= 1'b0;
         timeout <= 1'b0;
      end else begin
         timeout <= 1'b0;
         if (restart || !enable) begin // [R12]
            pre_reg <= 32'h0;
            ms_reg <= '0;
            expired_reg <= 1'b0;
         end else if (!expired_reg) begin
            pre_reg <= tick ? 32'h0 : pre_reg + 32'h1;
            if (tick) begin
               ms_reg <= ms_reg + 13'h1;
               if (ms_reg + 13'h1 >= limit) begin
                  expired_reg <= 1'b1;
                  timeout <= 1'b1;
               end
            end
         end
      end
   end
endmodule

// [verilog/loop_dac_control.sv]
// option bits, link watchdog and fault reporting of a loop-powered converter
// assumes a plain register port and comparator/pin levels synchronous to clock
`timescale 1ns/1ps
module loop_dac_control
   import loop_dac_pkg::*;
#(
   parameter int CYCLES_MS = CYCLES_PER_MS
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   input wire logic nop_cmd,
   input wire logic frame_check_error,
   input wire logic loop_supply_low,
   input wire logic alarm_dir_pin,
   output logic [DATA_W-1:0] fault_word,
   output logic fault_word_valid,
   output logic fault_alert_pin,
   output logic force_alarm,
   output logic alarm_upscale,
   output logic min_current,
   output logic monitor_sel_temp,
   output logic monitor_enable,
   output logic ref_power_down,
   output logic irq
);
   logic [DATA_W-1:0] ctrl_reg;
   logic link_fault_reg;
   logic frame_check_error_flag;
   logic loop_low_fault_reg;
   logic wr_hit;
   logic restart;
   logic link_timeout;
   logic [DATA_W-1:0] fault_now;
   logic [EV_W-1:0] ev_set;
   logic [EV_W-1:0] ev_status;
   logic [EV_W-1:0] ev_mask;
   logic loop_low_dly_reg;

   // a write counts as valid when it hits a mapped register
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == CTRL_OFS) || (a == FAULT_OFS) ||
               (a == STATUS_OFS) || (a == MASK_OFS);
   endfunction

   assign wr_hit = wr && mapped(addr);
   assign restart = wr_hit || nop_cmd; // [R12]

   // control register: fault offset writes fall through untouched
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
      end else if (wr && addr == CTRL_OFS) begin
         ctrl_reg <= wdata & CTRL_WR_MASK; // [R14]
      end
   end

   link_watchdog #(
      .CYCLES_MS(CYCLES_MS)
   ) u_watchdog (
      .clock(clock),
      .rst(rst),
      .enable(ctrl_reg[CTL_WD_EN]),
      .restart(restart),
      .period_sel(ctrl_reg[CTL_TMO_HI:CTL_TMO_LO]),
      .timeout(link_timeout)
   );

   // link fault holds until the host talks again; set beats clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         link_fault_reg <= 1'b0;
      end else if (link_timeout) begin
         link_fault_reg <= 1'b1; // [R3]
      end else if (restart) begin
         link_fault_reg <= 1'b0;
      end
   end

   // frame check error stays until the next clean mapped write
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         frame_check_error_flag <= 1'b0;
      end else if (frame_check_error) begin
         frame_check_error_flag <= 1'b1;
      end else if (wr_hit) begin
         frame_check_error_flag <= 1'b0;
      end
   end

   // low loop voltage bit tracks the comparator regardless of alert option
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         loop_low_fault_reg <= 1'b0;
         loop_low_dly_reg <= 1'b0;
      end else begin
         loop_low_fault_reg <= loop_supply_low; // [R9]
         loop_low_dly_reg <= loop_low_fault_reg;
      end
   end

   // fault word assembled from detected conditions only
   always_comb begin
      fault_now = '0;
      fault_now[FLT_LINK] = link_fault_reg; // [R10]
      fault_now[FLT_FRAME] = frame_check_error_flag;
      fault_now[FLT_LOOP_LOW] = loop_low_fault_reg;
   end

   // automatic readback: a write or no-op shifts the fault word out
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fault_word <= '0;
         fault_word_valid <= 1'b0;
      end else begin
         fault_word_valid <= 1'b0;
         if ((wr || nop_cmd) && !ctrl_reg[CTL_NO_READBACK]) begin // [R1]
            fault_word <= fault_now;
            fault_word_valid <= 1'b1;
         end
      end
   end

   // analog steering outputs, registered to keep them glitch free
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         force_alarm <= 1'b0;
         alarm_upscale <= 1'b0;
         min_current <= 1'b0;
         monitor_sel_temp <= 1'b0;
         monitor_enable <= 1'b0;
         ref_power_down <= 1'b0;
      end else begin
         force_alarm <= link_fault_reg && !ctrl_reg[CTL_NO_ALARM]; // [R2] [R4]
         alarm_upscale <= alarm_dir_pin; // [R13]
         min_current <= ctrl_reg[CTL_MIN_CURRENT]; // [R5]
         monitor_sel_temp <= ctrl_reg[CTL_MON_TEMP]; // [R6]
         monitor_enable <= ctrl_reg[CTL_MON_EN]; // [R11]
         ref_power_down <= ctrl_reg[CTL_REF_OFF]; // [R7]
      end
   end

   // alert pin: link and frame faults always, low loop only when allowed
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fault_alert_pin <= 1'b0;
      end else begin
         fault_alert_pin <= link_fault_reg || frame_check_error_flag || // [R3]
            (loop_low_fault_reg && ctrl_reg[CTL_LOOP_ALERT]); // [R8]
      end
   end

   // link and frame events take their input pulses; low loop fires on its rising edge
   always_comb begin
      ev_set = '0;
      ev_set[EV_LINK] = link_timeout;
      ev_set[EV_FRAME] = frame_check_error;
      ev_set[EV_LOOP_LOW] = loop_low_fault_reg && !loop_low_dly_reg;
   end

   event_flags #(
      .W(EV_W)
   ) u_flags (
      .clock(clock),
      .rst(rst),
      .set(ev_set),
      .clear_wr(wr && addr == STATUS_OFS),
      .mask_wr(wr && addr == MASK_OFS),
      .wdata(wdata[EV_W-1:0]),
      .status(ev_status),
      .mask(ev_mask),
      .irq(irq)
   );

   // read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else if (rd) begin
         case (addr)
            CTRL_OFS: rdata <= ctrl_reg;
            FAULT_OFS: rdata <= fault_now; // [R10]
            STATUS_OFS: rdata <= {13'h0, ev_status};
            MASK_OFS: rdata <= {13'h0, ev_mask};
            default: rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   chk_readback_off: assert property ( // [R1]
      ctrl_reg[CTL_NO_READBACK] && wr |=> !fault_word_valid)
      else $error("fault word sent with readback off");

   chk_readback_on: assert property ( // [R1]
      !ctrl_reg[CTL_NO_READBACK] && nop_cmd |=> fault_word_valid)
      else $error("fault word missing on no-op");

   chk_alarm_forced: assert property ( // [R2]
      link_fault_reg && !ctrl_reg[CTL_NO_ALARM] |=> force_alarm)
      else $error("alarm current not forced");

   chk_timeout_alert: assert property ( // [R3]
      link_timeout |=> link_fault_reg ##1 fault_alert_pin)
      else $error("link timeout did not raise alert");

   chk_alarm_held_off: assert property ( // [R4]
      ctrl_reg[CTL_NO_ALARM] |=> !force_alarm)
      else $error("alarm forced though option is 1");

   chk_min_current: assert property ( // [R5]
      $rose(ctrl_reg[CTL_MIN_CURRENT]) |=> min_current)
      else $error("minimum current not applied");

   chk_loop_alert: assert property ( // [R8]
      !link_fault_reg && !frame_check_error_flag &&
      !ctrl_reg[CTL_LOOP_ALERT] |=> !fault_alert_pin)
      else $error("alert raised for masked loop voltage");

   chk_loop_status: assert property ( // [R9]
      loop_supply_low ##1 loop_supply_low |-> loop_low_fault_reg)
      else $error("loop voltage fault bit not set");

   chk_fault_ro: assert property ( // [R10]
      wr && addr == FAULT_OFS |=> $stable(ctrl_reg))
      else $error("fault write altered control");

   chk_restart_clears: assert property ( // [R12]
      restart && !link_timeout |=> !link_fault_reg [*2])
      else $error("link fault kept after restart");

   chk_irq_level: assert property (
      (ev_status & ev_mask) != '0 |-> irq)
      else $error("interrupt low with unmasked event");

   // steering outputs follow their control bits or the alarm direction pin one cycle late
   chk_min_normal: assert property ( // [R5]
      !ctrl_reg[CTL_MIN_CURRENT] |=> !min_current)
      else $error("minimum current held while bit is 0");

   chk_monitor_temp: assert property ( // [R6]
      ctrl_reg[CTL_MON_TEMP] |=> monitor_sel_temp)
      else $error("monitor not routed to die temperature");

   chk_monitor_loop: assert property ( // [R6]
      !ctrl_reg[CTL_MON_TEMP] |=> !monitor_sel_temp)
      else $error("monitor not routed to loop supply");

   chk_ref_down: assert property ( // [R7]
      ctrl_reg[CTL_REF_OFF] |=> ref_power_down)
      else $error("reference left powered");

   chk_ref_up: assert property ( // [R7]
      !ctrl_reg[CTL_REF_OFF] |=> !ref_power_down)
      else $error("reference powered down while bit is 0");

   chk_monitor_on: assert property ( // [R11]
      ctrl_reg[CTL_MON_EN] |=> monitor_enable)
      else $error("monitor converter not running");

   chk_monitor_off: assert property ( // [R11]
      !ctrl_reg[CTL_MON_EN] |=> !monitor_enable)
      else $error("monitor converter running while disabled");

   chk_alarm_up: assert property ( // [R13]
      alarm_dir_pin |=> alarm_upscale)
      else $error("alarm direction not upscale");

   chk_alarm_down: assert property ( // [R13]
      !alarm_dir_pin |=> !alarm_upscale)
      else $error("alarm direction not downscale");

   // fault reporting: word content, read path, status and alert
   chk_fault_word: assert property ( // [R1]
      (wr || nop_cmd) && !ctrl_reg[CTL_NO_READBACK] |=> fault_word == $past(fault_now))
      else $error("readback word differs from fault state");

   chk_fault_read: assert property ( // [R10]
      rd && addr == FAULT_OFS |=> rdata == $past(fault_now))
      else $error("fault read differs from fault state");

   chk_timeout_status: assert property ( // [R3]
      link_timeout |=> ev_status[EV_LINK])
      else $error("link timeout not flagged in status");

   chk_loop_raise: assert property ( // [R8]
      loop_low_fault_reg && ctrl_reg[CTL_LOOP_ALERT] |=> fault_alert_pin)
      else $error("alert missing for low loop voltage");

   // a stopped watchdog must never report a lost link
   chk_wd_disabled: assert property ( // [R12]
      !ctrl_reg[CTL_WD_EN] |=> !link_timeout)
      else $error("timeout while watchdog disabled");

   cov_link_alarm: cover property (link_timeout ##2 force_alarm);
   cov_readback: cover property (wr ##1 fault_word_valid);
   cov_loop_irq: cover property ($rose(loop_low_fault_reg) ##[1:3] irq);
   cov_frame_alert: cover property (frame_check_error ##2 fault_alert_pin);
   cov_min_current: cover property ($rose(min_current));
endmodule

// [verilog/loop_dac_pkg.sv]
// constants, register map and field layout of the loop converter control block
// assumes a 200 mhz clock and a plain one-cycle register port
// What this block does
// [R1] auto readback bit 1 stops the fault word going out on writes
// [R2] alarm option 0 (default) forces alarm current on link watchdog timeout
// [R3] link timeout always sets link fault bit and fault alert pin
// [R4] alarm option 1 leaves loop current programmed after link timeout
// [R5] min current bit 1 drives output to minimum; 0 is normal
// [R6] monitor input select: loop supply voltage by default, else die temperature
// [R7] reference powered by default; power-down bit turns it off
// [R8] loop voltage alert bit 1 lets low loop voltage raise alert pin
// [R9] low loop voltage always sets its fault status bit
// [R10] fault register is read-only and reports detected faults
// [R11] monitor converter runs only while enabled; disabled after reset
// [R12] watchdog restarts on valid write or no-op; 50 ms to 5 s, 1 s default
// [R13] alarm direction follows the alarm direction select pin
// [R14] alarm option sits at control bit 10; zero enables forcing
package loop_dac_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] FAULT_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] MASK_OFS = 8'h0c;
   // control field positions
   localparam int CTL_TMO_HI = 15;
   localparam int CTL_TMO_LO = 13;
   localparam int CTL_WD_EN = 12;
   localparam int CTL_NO_READBACK = 11;
   localparam int CTL_NO_ALARM = 10;
   localparam int CTL_MIN_CURRENT = 9;
   localparam int CTL_MON_TEMP = 8;
   localparam int CTL_MON_EN = 7;
   localparam int CTL_REF_OFF = 6;
   localparam int CTL_LOOP_ALERT = 5;
   // timeout 1 s, watchdog on, everything else zero
   localparam logic [15:0] CTRL_RESET = 16'h7000;
   localparam logic [15:0] CTRL_WR_MASK = 16'hffe0;
   // fault word bit positions
   localparam int FLT_LINK = 15;
   localparam int FLT_FRAME = 14;
   localparam int FLT_LOOP_LOW = 8;
   // sticky event bits
   localparam int EV_W = 3;
   localparam int EV_LINK = 0;
   localparam int EV_FRAME = 1;
   localparam int EV_LOOP_LOW = 2;
   localparam logic [2:0] EV_RESET = 3'h0;
   // timing
   localparam int CLOCK_PERIOD_PS = 5000;
   localparam int MS_PS = 1000000000;
   localparam int CYCLES_PER_MS = MS_PS / CLOCK_PERIOD_PS;
   localparam int MS_W = 13;

   // watchdog period in ms for the 3-bit select
   function automatic logic [12:0] timeout_ms(input logic [2:0] sel);
      case (sel)
         3'h0: timeout_ms = 13'd50;
         3'h1: timeout_ms = 13'd100;
         3'h2: timeout_ms = 13'd500;
         3'h3: timeout_ms = 13'd1000;
         3'h4: timeout_ms = 13'd2000;
         3'h5: timeout_ms = 13'd3000;
         3'h6: timeout_ms = 13'd4000;
         default: timeout_ms = 13'd5000;
      endcase
   endfunction
endpackage
